// ===== dv/sbpfe_host_model.sv
// Host serial port model: 8N1 frames with software flow control
`timescale 1ns/1ps
`default_nettype none
module sbpfe_host_model #(
   parameter BIT = 16
) (
   // Clock
   input wire logic sys_clk,
   // Serial lines
   input wire logic devTx,
   output logic hostTx
);
   logic [7:0] rxQ[$];
   logic held = 1'b0;
   logic [7:0] b;
   initial hostTx = 1'b1;
   task automatic sendChar(input logic [7:0] c);
      int i;
      while (held) @(negedge sys_clk);
      for (i = 0; i < 10; i++) begin
         @(negedge sys_clk);
         hostTx = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i-1];
         repeat (BIT - 1) @(negedge sys_clk);
      end
   endtask
   // mid-bit sampling, flow codes kept aside
   always begin
      @(negedge devTx);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge sys_clk);
         b[i] = devTx;
      end
      repeat (BIT) @(posedge sys_clk);
      if (b == 8'h13) held = 1'b1;
      else if (b == 8'h11) held = 1'b0;
      else rxQ.push_back(b);
   end
endmodule // sbpfe_host_model
`default_nettype wire

// ===== dv/sbpfe_monitor.sv
// Assertion checker for the serial boot programming front end
`timescale 1ns/1ps
`default_nettype none
module sbpfe_monitor #(
   parameter DIV_W = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Boot decision
   input wire logic flashRdEn,
   input wire logic [2:0] flashRdIdx,
   input wire logic mirrorBootAtZero,
   input wire logic runUser,
   input wire logic inSession,
   // Serial and line side
   input wire logic serialTx,
   input wire logic lineCharValid,
   input wire logic lineEnd,
   input wire logic abortCmd,
   input wire logic cmdRejected,
   input wire logic [DIV_W-1:0] baudDiv
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   chk_fetch_len: assert property ($rose(flashRdEn) |-> flashRdEn [*8] ##1 !flashRdEn)
      else $error("vector fetch not eight words");
   chk_fetch_step: assert property (flashRdEn && $past(flashRdEn) |->
      flashRdIdx == $past(flashRdIdx) + 3'h1)
      else $error("vector index skipped");
   chk_user_unmap: assert property (runUser |-> !mirrorBootAtZero)
      else $error("mirror kept while user runs");
   chk_path_excl: assert property (inSession |-> !runUser)
      else $error("session and user code together");
   chk_tx_idle: assert property (!inSession |-> serialTx)
      else $error("transmit line not idle");
   chk_reject_end: assert property (cmdRejected |-> lineEnd)
      else $error("refusal outside line end");
   chk_end_pulse: assert property (lineEnd |=> !lineEnd)
      else $error("empty line reported");
   chk_abort_alone: assert property (abortCmd |-> !lineCharValid && !lineEnd)
      else $error("abort passed as line data");
   chk_div_floor: assert property (inSession |-> baudDiv >= 16'h0004)
      else $error("baud divider below floor");
   cov_user: cover property ($rose(runUser));
   cov_session: cover property ($rose(inSession));
   cov_reject: cover property (cmdRejected);
   cov_abort: cover property (abortCmd);
endmodule // sbpfe_monitor

bind sbpfe_top sbpfe_monitor #(.DIV_W(DIV_W)) mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
   .flashRdEn(flashRdEn), .flashRdIdx(flashRdIdx), .mirrorBootAtZero(mirrorBootAtZero),
   .runUser(runUser), .inSession(inSession), .serialTx(serialTx),
   .lineCharValid(lineCharValid), .lineEnd(lineEnd), .abortCmd(abortCmd),
   .cmdRejected(cmdRejected), .baudDiv(baudDiv));
`default_nettype wire

// ===== dv/tb_serial_boot_programming_front_end.sv
// Testbench for the serial boot programming front end
`timescale 1ns/1ps
`default_nettype none
module tb_serial_boot_programming_front_end;
   logic sys_clk = 1'b0, sys_rst, progReqPin_n;
   logic flashRdEn, mirrorBootAtZero, runUser, inSession, serialRx, serialTx;
   logic [2:0] flashRdIdx;
   logic [31:0] vec[8];
   logic [31:0] flashRdData;
   logic [7:0] lineChar;
   logic lineCharValid, lineEnd, abortCmd, cmdRejected, txCharReady;
   logic cmdIsUnlock, cmdIsGuarded, unlockOk, txCharValid;
   logic [7:0] txChar;
   logic [15:0] baudDiv;
   logic [7:0] lineBuf[$];
   int fail_count = 0, checked = 0, endCount = 0, rejCount = 0, abortCount = 0;
   assign flashRdData = vec[flashRdIdx];
   always #10 sys_clk = ~sys_clk;
   sbpfe_top #(.DIV_W(16)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .progReqPin_n(progReqPin_n), .flashRdEn(flashRdEn), .flashRdIdx(flashRdIdx),
      .flashRdData(flashRdData), .mirrorBootAtZero(mirrorBootAtZero), .runUser(runUser),
      .inSession(inSession), .serialRx(serialRx), .serialTx(serialTx), .lineChar(lineChar),
      .lineCharValid(lineCharValid), .lineEnd(lineEnd), .abortCmd(abortCmd),
      .cmdRejected(cmdRejected), .cmdIsUnlock(cmdIsUnlock), .cmdIsGuarded(cmdIsGuarded),
      .unlockOk(unlockOk), .txChar(txChar), .txCharValid(txCharValid),
      .txCharReady(txCharReady), .baudDiv(baudDiv));
   sbpfe_host_model #(.BIT(16)) host (.sys_clk(sys_clk), .devTx(serialTx), .hostTx(serialRx));
   always @(posedge sys_clk) begin
      if (lineCharValid === 1'b1) lineBuf.push_back(lineChar);
      if (lineEnd === 1'b1) endCount++;
      if (cmdRejected === 1'b1) rejCount++;
      if (abortCmd === 1'b1) abortCount++;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         fail_count++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task automatic boot(input logic pin, input logic good);
      vec[7] = 32'h0;
      for (int i = 0; i < 7; i++) begin
         vec[i] = 32'h10000000 * i + 32'h2001;
         vec[7] = vec[7] - vec[i];
      end
      if (!good) vec[7] = vec[7] + 32'h1;
      @(negedge sys_clk);
      progReqPin_n = pin;
      sys_rst = 1'b1;
      repeat (20) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (40) @(negedge sys_clk);
   endtask
   task automatic sendStr(input string s);
      foreach (s[i]) host.sendChar(s[i]);
   endtask
   task automatic expectStr(input string s);
      int n;
      foreach (s[i]) begin
         n = 0;
         while (host.rxQ.size() == 0 && n < 2000) begin
            @(posedge sys_clk);
            n++;
         end
         check(host.rxQ.size() > 0 && host.rxQ.pop_front() === s[i], "reply text");
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_boot;
      boot(1'b1, 1'b1);
      check(runUser === 1'b1 && inSession === 1'b0, "good image not run");
      check(mirrorBootAtZero === 1'b0, "mirror kept");
      boot(1'b0, 1'b1);
      check(inSession === 1'b1 && runUser === 1'b0, "request pin ignored");
      boot(1'b1, 1'b0);
      check(inSession === 1'b1 && runUser === 1'b0, "bad image run");
      check(mirrorBootAtZero === 1'b1, "mirror lost");
   endtask
   task automatic t_sync;
      host.sendChar(8'h3f);
      expectStr("Synchronized\r\n");
      check(baudDiv >= 16'h000f && baudDiv <= 16'h0011, "bit time");
      sendStr("Synchronizes\r\n");
      repeat (400) @(negedge sys_clk);
      check(host.rxQ.size() == 0, "reply to wrong echo");
      host.sendChar(8'h3f);
      expectStr("Synchronized\r\n");
      sendStr("Synchronized\r\n");
      expectStr("OK\r\n");
      sendStr("12000\r\n");
      expectStr("OK\r\n");
      repeat (100) @(negedge sys_clk);
   endtask
   task automatic t_lines;
      lineBuf.delete();
      endCount = 0;
      sendStr("J\r\n\r\n");
      repeat (200) @(negedge sys_clk);
      check(endCount == 1 && lineBuf.size() == 1 && lineBuf[0] === 8'h4a, "framing");
   endtask
   task automatic t_lock;
      rejCount = 0;
      cmdIsGuarded = 1'b1;
      sendStr("E 0 1\r");
      repeat (200) @(negedge sys_clk);
      check(rejCount == 1, "locked command taken");
      cmdIsGuarded = 1'b0;
      cmdIsUnlock = 1'b1;
      sendStr("U 1\r");
      repeat (200) @(negedge sys_clk);
      cmdIsUnlock = 1'b0;
      cmdIsGuarded = 1'b1;
      sendStr("W 0 4\r");
      repeat (200) @(negedge sys_clk);
      check(rejCount == 2, "failed unlock opened lock");
      cmdIsGuarded = 1'b0;
      cmdIsUnlock = 1'b1;
      unlockOk = 1'b1;
      sendStr("U 23130\r");
      repeat (200) @(negedge sys_clk);
      cmdIsUnlock = 1'b0;
      unlockOk = 1'b0;
      cmdIsGuarded = 1'b1;
      sendStr("G 0 T\r");
      repeat (200) @(negedge sys_clk);
      check(rejCount == 2, "unlocked command refused");
      cmdIsGuarded = 1'b0;
   endtask
   task automatic t_abort;
      abortCount = 0;
      sendStr("R 0 4");
      host.sendChar(8'h1b);
      repeat (200) @(negedge sys_clk);
      check(abortCount == 1, "escape ignored");
   endtask
   task automatic t_flow;
      int n;
      host.sendChar(8'h13);
      repeat (40) @(negedge sys_clk);
      txChar = 8'h41;
      txCharValid = 1'b1;
      repeat (80) @(negedge sys_clk);
      check(txCharReady === 1'b0 && host.rxQ.size() == 0, "sent while stopped");
      host.sendChar(8'h11);
      n = 0;
      while (txCharReady !== 1'b1 && n < 500) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      txCharValid = 1'b0;
      expectStr("A");
   endtask
   task automatic conclude;
      $display("Mismatches %0d, checks %0d", fail_count, checked);
      if (fail_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      sys_rst = 1'b1;
      progReqPin_n = 1'b1;
      cmdIsUnlock = 1'b0;
      cmdIsGuarded = 1'b0;
      unlockOk = 1'b0;
      txCharValid = 1'b0;
      txChar = 8'h00;
      t_boot;
      t_sync;
      t_lines;
      t_lock;
      t_abort;
      t_flow;
      conclude;
   end
   // Watchdog: whole run needs about 21k cycles
   initial begin
      repeat (80000) @(posedge sys_clk);
      fail_count++;
      conclude;
   end
endmodule // tb_serial_boot_programming_front_end
`default_nettype wire

// ===== src/sbpfe_fifo.v
// Receive character FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module sbpfe_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   // Clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // Fill side
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   // Drain side
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData,
   // Fill level
   output wire [AW:0] level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_reg;
   reg [AW-1:0] rdPtr_reg;
   reg [AW:0] count_reg;
   wire doWrite;
   wire doRead;

   assign inReady = (count_reg != DEPTH[AW:0]);
   assign outValid = (count_reg != {(AW+1){1'b0}});
   assign outData = mem[rdPtr_reg];
   assign level = count_reg;
   assign doWrite = inValid && inReady;
   assign doRead = outValid && outReady;

   always @(posedge sys_clk) begin
      if (doWrite) begin
         mem[wrPtr_reg] <= inData;
      end
   end

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPtr_reg <= {AW{1'b0}};
         rdPtr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (doWrite) begin
            wrPtr_reg <= (wrPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr_reg + 1'b1;
         end
         if (doRead) begin
            rdPtr_reg <= (rdPtr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr_reg + 1'b1;
         end
         if (doWrite && !doRead) begin
            count_reg <= count_reg + 1'b1;
         end else if (doRead && !doWrite) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // sbpfe_fifo
`default_nettype wire

// ===== src/sbpfe_regs.vh
// Constants for the serial boot programming front end
// How it works
// - After reset, boot block sits high and its lowest 512 bytes mirror at zero.
// - Sum first eight flash words; run user code only if sum is zero.
// - Failed signature sends device into serial auto-baud synchronisation.
// - Frames are eight data bits, one stop bit, no parity.
// - Device times sync bit, loads baud divider, sends Synchronized CR LF.
// - Host echoes Synchronized line; device answers OK or resumes waiting.
// - Host sends frequency line; device answers OK and starts command handler.
// - Device runs on internal oscillator and ignores the frequency value.
// - Erase, write and go are rejected until unlock succeeds once.
// - Command lines end in CR and/or LF; extra terminators are dropped.
// - Device answers return-code line, response lines, data only for reads.
// - Binary payload is UU-encoded, three bytes to four characters.
// - UU line holds at most 61 characters and 45 payload bytes.
// - Checksum after twenty lines; receiver answers OK or RESEND.
// - DC3 halts incoming traffic, DC1 resumes; both ends honour it.
// - ESC abandons the current command and awaits a fresh line.
// - Low programming request pin at reset skips the signature check.
`ifndef SBPFE_REGS_VH
`define SBPFE_REGS_VH

`define SBPFE_BOOT_BASE 32'h1fff0000
`define SBPFE_BOOT_SIZE 32'h00004000
`define SBPFE_MIRROR_SIZE 32'h00000200
`define SBPFE_SIG_WORDS 4'h8
`define SBPFE_SIG_SLOT 3'h7
`define SBPFE_CH_SYNC 8'h3f
`define SBPFE_CH_CR 8'h0d
`define SBPFE_CH_LF 8'h0a
`define SBPFE_CH_ESC 8'h1b
`define SBPFE_CH_XON 8'h11
`define SBPFE_CH_XOFF 8'h13
`define SBPFE_CH_SPACE 8'h20
`define SBPFE_DATA_BITS 4'h8
`define SBPFE_UU_MAX_CHARS 7'h3d
`define SBPFE_UU_MAX_BYTES 6'h2d
`define SBPFE_UU_GROUP_LINES 5'h14
`define SBPFE_LINE_MAX 7'h40
`define SBPFE_FIFO_DEPTH 8
`define SBPFE_FIFO_HIGH 4'h6
`define SBPFE_FIFO_LOW 4'h2
`define SBPFE_DIV_MIN 16'h0004
`define SBPFE_STRAP_WAIT 2'h2

`endif

// ===== src/sbpfe_top.v
// Serial boot programming front end: boot decision, auto-baud, line protocol
`timescale 1ns/1ps
`default_nettype none
`include "sbpfe_regs.vh"
module sbpfe_top #(
   parameter DIV_W = 16
) (
   // Clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // Programming request pin, active low, async
   input wire progReqPin_n,
   // Flash vector fetch
   output reg flashRdEn,
   output reg [2:0] flashRdIdx,
   input wire [31:0] flashRdData,
   // Address remap and boot outcome
   output reg mirrorBootAtZero,
   output reg runUser,
   output reg inSession,
   // Serial pins
   input wire serialRx,
   output reg serialTx,
   // Command line to the handler
   output reg [7:0] lineChar,
   output reg lineCharValid,
   output reg lineEnd,
   output reg abortCmd,
   output reg cmdRejected,
   // Handler controls
   input wire cmdIsUnlock,
   input wire cmdIsGuarded,
   input wire unlockOk,
   // Handler transmit characters
   input wire [7:0] txChar,
   input wire txCharValid,
   output wire txCharReady,
   // Baud divider in use
   output reg [DIV_W-1:0] baudDiv
);
   // ---------------------------------------------
   // States
   // ---------------------------------------------
   localparam ST_SIG = 3'h0;
   localparam ST_WAITQ = 3'h1;
   localparam ST_SENDSYNC = 3'h2;
   localparam ST_CHKSYNC = 3'h3;
   localparam ST_SENDOK1 = 3'h4;
   localparam ST_FREQ = 3'h5;
   localparam ST_SENDOK2 = 3'h6;
   localparam ST_CMD = 3'h7;

   // Reply text, indexed from 0; Synchronized CR LF is 14 chars, OK CR LF 4
   function [7:0] syncText;
      input [3:0] i;
      begin
         case (i)
            4'h0: syncText = 8'h53;
            4'h1: syncText = 8'h79;
            4'h2: syncText = 8'h6e;
            4'h3: syncText = 8'h63;
            4'h4: syncText = 8'h68;
            4'h5: syncText = 8'h72;
            4'h6: syncText = 8'h6f;
            4'h7: syncText = 8'h6e;
            4'h8: syncText = 8'h69;
            4'h9: syncText = 8'h7a;
            4'ha: syncText = 8'h65;
            4'hb: syncText = 8'h64;
            4'hc: syncText = `SBPFE_CH_CR;
            default: syncText = `SBPFE_CH_LF;
         endcase
      end
   endfunction

   function [7:0] okText;
      input [1:0] i;
      begin
         case (i)
            2'h0: okText = 8'h4f;
            2'h1: okText = 8'h4b;
            2'h2: okText = `SBPFE_CH_CR;
            default: okText = `SBPFE_CH_LF;
         endcase
      end
   endfunction

   // ---------------------------------------------
   // Input synchronisers
   // ---------------------------------------------
   reg rxMeta_reg, rxSync_reg, reqMeta_reg, reqSync_reg;
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxMeta_reg <= 1'b1;
         rxSync_reg <= 1'b1;
         reqMeta_reg <= 1'b1;
         reqSync_reg <= 1'b1;
      end else begin
         rxMeta_reg <= serialRx;
         rxSync_reg <= rxMeta_reg;
         reqMeta_reg <= progReqPin_n;
         reqSync_reg <= reqMeta_reg;
      end
   end

   reg [2:0] state_reg;
   reg [3:0] sigCnt_reg;
   reg [31:0] sigSum_reg;
   reg strapTaken_reg;
   reg [1:0] strapWait_reg;
   reg unlocked_reg;
   reg xoffSeen_reg;
   reg xoffSent_reg;

   // ---------------------------------------------
   // Receiver with auto-baud
   // ---------------------------------------------
   // Sync '?' starts with one low bit (start) then LSB 1: start bit width is one bit
   reg rxBusy_reg, rxMeas_reg, rxPrev_reg;
   reg [DIV_W-1:0] rxCnt_reg;
   reg [3:0] rxBit_reg;
   reg [7:0] rxShift_reg;
   reg rxStrobe;
   wire autoBaud = (state_reg == ST_WAITQ);
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxBusy_reg <= 1'b0;
         rxMeas_reg <= 1'b0;
         rxPrev_reg <= 1'b1;
         rxCnt_reg <= {DIV_W{1'b0}};
         rxBit_reg <= 4'h0;
         rxShift_reg <= 8'h00;
         rxStrobe <= 1'b0;
         baudDiv <= `SBPFE_DIV_MIN;
      end else begin
         rxPrev_reg <= rxSync_reg;
         rxStrobe <= 1'b0;
         if (autoBaud && !rxMeas_reg && !rxBusy_reg) begin
            if (rxPrev_reg && !rxSync_reg) begin
               rxMeas_reg <= 1'b1;
               rxCnt_reg <= {DIV_W{1'b0}};
            end
         end else if (rxMeas_reg) begin
            rxCnt_reg <= rxCnt_reg + 1'b1;
            if (rxSync_reg) begin
               rxMeas_reg <= 1'b0;
               // Low time is the count plus the detecting cycle
               baudDiv <= (rxCnt_reg < `SBPFE_DIV_MIN) ? `SBPFE_DIV_MIN : rxCnt_reg + 1'b1;
               rxBusy_reg <= 1'b1;
               rxBit_reg <= 4'h1;
               rxShift_reg <= 8'h00;
               // Half a bit in hand so data is sampled mid-bit
               rxCnt_reg <= {1'b0, rxCnt_reg[DIV_W-1:1]};
            end
         end else if (!rxBusy_reg) begin
            if (rxPrev_reg && !rxSync_reg) begin
               rxBusy_reg <= 1'b1;
               rxBit_reg <= 4'h0;
               rxCnt_reg <= {1'b0, baudDiv[DIV_W-1:1]};
            end
         end else if (rxCnt_reg == baudDiv - 1'b1) begin
            rxCnt_reg <= {DIV_W{1'b0}};
            if (rxBit_reg == `SBPFE_DATA_BITS + 4'h1) begin
               rxBusy_reg <= 1'b0;
               rxStrobe <= rxSync_reg;
            end else begin
               if (rxBit_reg != 4'h0) begin
                  rxShift_reg <= {rxSync_reg, rxShift_reg[7:1]};
               end
               rxBit_reg <= rxBit_reg + 4'h1;
            end
         end else begin
            rxCnt_reg <= rxCnt_reg + 1'b1;
         end
      end
   end

   // ---------------------------------------------
   // Receive FIFO and XON/XOFF toward host
   // ---------------------------------------------
   wire fifoInReady, fifoOutValid;
   wire [7:0] fifoOut;
   wire [3:0] fifoLevel;
   reg fifoPop;
   wire isFlow = (rxShift_reg == `SBPFE_CH_XON) || (rxShift_reg == `SBPFE_CH_XOFF);
   // Only draining states fill; a stale sync char would spoil the echo check
   wire rxKeep = (state_reg == ST_CHKSYNC) || (state_reg == ST_FREQ) || (state_reg == ST_CMD);
   sbpfe_fifo #(.WIDTH(8), .DEPTH(`SBPFE_FIFO_DEPTH), .AW(3)) rxFifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .inValid(rxStrobe && !isFlow && rxKeep),
      .inReady(fifoInReady),
      .inData(rxShift_reg),
      .outValid(fifoOutValid),
      .outReady(fifoPop),
      .outData(fifoOut),
      .level(fifoLevel)
   );

   // ---------------------------------------------
   // Transmitter
   // ---------------------------------------------
   reg txBusy_reg;
   reg [3:0] txBit_reg;
   reg [DIV_W-1:0] txCnt_reg;
   reg [8:0] txShift_reg;
   reg [7:0] txLoad;
   reg txGo;
   reg flowPend_reg;
   reg flowChar_reg;
   wire txFree = !txBusy_reg && !xoffSeen_reg;
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         txBusy_reg <= 1'b0;
         txBit_reg <= 4'h0;
         txCnt_reg <= {DIV_W{1'b0}};
         txShift_reg <= 9'h1ff;
         serialTx <= 1'b1;
      end else if (!txBusy_reg) begin
         if (txGo) begin
            txBusy_reg <= 1'b1;
            txShift_reg <= {1'b1, txLoad};
            serialTx <= 1'b0;
            txBit_reg <= 4'h0;
            txCnt_reg <= {DIV_W{1'b0}};
         end
      end else if (txCnt_reg == baudDiv - 1'b1) begin
         txCnt_reg <= {DIV_W{1'b0}};
         if (txBit_reg == `SBPFE_DATA_BITS + 4'h1) begin
            txBusy_reg <= 1'b0;
         end else begin
            serialTx <= txShift_reg[0];
            txShift_reg <= {1'b1, txShift_reg[8:1]};
            txBit_reg <= txBit_reg + 4'h1;
         end
      end else begin
         txCnt_reg <= txCnt_reg + 1'b1;
      end
   end

   // ---------------------------------------------
   // Session sequencer
   // ---------------------------------------------
   reg [3:0] txIdx_reg;
   reg [3:0] chkIdx_reg;
   reg chkBad_reg;
   reg lastTerm_reg;
   wire [7:0] ch = fifoOut;
   wire isTerm = (ch == `SBPFE_CH_CR) || (ch == `SBPFE_CH_LF);
   assign txCharReady = (state_reg == ST_CMD) && txFree && !flowPend_reg;

   always @* begin
      txGo = 1'b0;
      txLoad = 8'h00;
      if (txFree || (!txBusy_reg && flowPend_reg)) begin
         if (flowPend_reg) begin
            txGo = 1'b1;
            txLoad = flowChar_reg ? `SBPFE_CH_XOFF : `SBPFE_CH_XON;
         end else if (state_reg == ST_SENDSYNC) begin
            txGo = 1'b1;
            txLoad = syncText(txIdx_reg);
         end else if (state_reg == ST_SENDOK1 || state_reg == ST_SENDOK2) begin
            txGo = 1'b1;
            txLoad = okText(txIdx_reg[1:0]);
         end else if (state_reg == ST_CMD && txCharValid) begin
            txGo = 1'b1;
            txLoad = txChar;
         end
      end
   end

   always @* begin
      fifoPop = fifoOutValid && (state_reg == ST_CHKSYNC || state_reg == ST_FREQ
                                 || state_reg == ST_CMD);
   end

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_SIG;
         sigCnt_reg <= 4'h0;
         sigSum_reg <= 32'h00000000;
         strapTaken_reg <= 1'b0;
         strapWait_reg <= 2'h0;
         unlocked_reg <= 1'b0;
         xoffSeen_reg <= 1'b0;
         xoffSent_reg <= 1'b0;
         flowPend_reg <= 1'b0;
         flowChar_reg <= 1'b0;
         txIdx_reg <= 4'h0;
         chkIdx_reg <= 4'h0;
         chkBad_reg <= 1'b0;
         lastTerm_reg <= 1'b1;
         flashRdEn <= 1'b0;
         flashRdIdx <= 3'h0;
         mirrorBootAtZero <= 1'b1;
         runUser <= 1'b0;
         inSession <= 1'b0;
         lineChar <= 8'h00;
         lineCharValid <= 1'b0;
         lineEnd <= 1'b0;
         abortCmd <= 1'b0;
         cmdRejected <= 1'b0;
      end else begin
         lineCharValid <= 1'b0;
         lineEnd <= 1'b0;
         abortCmd <= 1'b0;
         cmdRejected <= 1'b0;
         if (rxStrobe && rxShift_reg == `SBPFE_CH_XOFF) begin
            xoffSeen_reg <= 1'b1;
         end else if (rxStrobe && rxShift_reg == `SBPFE_CH_XON) begin
            xoffSeen_reg <= 1'b0;
         end
         if (!xoffSent_reg && fifoLevel >= `SBPFE_FIFO_HIGH) begin
            xoffSent_reg <= 1'b1;
            flowPend_reg <= 1'b1;
            flowChar_reg <= 1'b1;
         end else if (xoffSent_reg && fifoLevel <= `SBPFE_FIFO_LOW) begin
            xoffSent_reg <= 1'b0;
            flowPend_reg <= 1'b1;
            flowChar_reg <= 1'b0;
         end else if (txGo && flowPend_reg) begin
            flowPend_reg <= 1'b0;
         end
         case (state_reg)
            ST_SIG: begin
               mirrorBootAtZero <= 1'b1;
               if (!strapTaken_reg && strapWait_reg != `SBPFE_STRAP_WAIT) begin
                  // Pin is read only once both synchroniser stages hold it
                  strapWait_reg <= strapWait_reg + 2'h1;
               end else if (!strapTaken_reg) begin
                  strapTaken_reg <= 1'b1;
                  if (!reqSync_reg) begin
                     state_reg <= ST_WAITQ;
                     inSession <= 1'b1;
                  end else begin
                     flashRdEn <= 1'b1;
                     flashRdIdx <= 3'h0;
                  end
               end else if (flashRdEn) begin
                  sigSum_reg <= sigSum_reg + flashRdData;
                  sigCnt_reg <= sigCnt_reg + 4'h1;
                  if (sigCnt_reg == `SBPFE_SIG_WORDS - 4'h1) begin
                     flashRdEn <= 1'b0;
                  end else begin
                     flashRdIdx <= flashRdIdx + 3'h1;
                  end
               end else if (sigSum_reg == 32'h00000000) begin
                  runUser <= 1'b1;
                  mirrorBootAtZero <= 1'b0;
               end else begin
                  state_reg <= ST_WAITQ;
                  inSession <= 1'b1;
               end
            end
            ST_WAITQ: begin
               txIdx_reg <= 4'h0;
               if (rxStrobe && rxShift_reg == `SBPFE_CH_SYNC) begin
                  state_reg <= ST_SENDSYNC;
               end
            end
            ST_SENDSYNC: begin
               if (txGo && !flowPend_reg) begin
                  txIdx_reg <= txIdx_reg + 4'h1;
                  if (txIdx_reg == 4'hd) begin
                     state_reg <= ST_CHKSYNC;
                     chkIdx_reg <= 4'h0;
                     chkBad_reg <= 1'b0;
                  end
               end
            end
            ST_CHKSYNC: begin
               if (fifoOutValid) begin
                  if (ch != syncText(chkIdx_reg)) begin
                     chkBad_reg <= 1'b1;
                  end
                  chkIdx_reg <= chkIdx_reg + 4'h1;
                  if (chkIdx_reg == 4'hd) begin
                     txIdx_reg <= 4'h0;
                     state_reg <= (chkBad_reg || ch != `SBPFE_CH_LF) ? ST_WAITQ : ST_SENDOK1;
                  end
               end
            end
            ST_SENDOK1, ST_SENDOK2: begin
               if (txGo && !flowPend_reg) begin
                  txIdx_reg <= txIdx_reg + 4'h1;
                  if (txIdx_reg == 4'h3) begin
                     txIdx_reg <= 4'h0;
                     lastTerm_reg <= 1'b1;
                     unlocked_reg <= 1'b0;
                     state_reg <= (state_reg == ST_SENDOK1) ? ST_FREQ : ST_CMD;
                  end
               end
            end
            ST_FREQ: begin
               if (fifoOutValid && ch == `SBPFE_CH_LF) begin
                  state_reg <= ST_SENDOK2;
               end
            end
            ST_CMD: begin
               if (cmdIsUnlock && unlockOk) begin
                  unlocked_reg <= 1'b1;
               end
               if (fifoOutValid) begin
                  if (ch == `SBPFE_CH_ESC) begin
                     abortCmd <= 1'b1;
                     lastTerm_reg <= 1'b1;
                  end else if (isTerm) begin
                     if (!lastTerm_reg) begin
                        lineEnd <= 1'b1;
                        cmdRejected <= cmdIsGuarded && !unlocked_reg;
                     end
                     lastTerm_reg <= 1'b1;
                  end else begin
                     lineChar <= ch;
                     lineCharValid <= 1'b1;
                     lastTerm_reg <= 1'b0;
                  end
               end
            end
            default: state_reg <= ST_SIG;
         endcase
      end
   end
endmodule // sbpfe_top
`default_nettype wire
